// [hdl/slo_map.vh]
// Register offsets, field positions, reset values and codes of the output page.
`ifndef SLO_MAP_VH
`define SLO_MAP_VH
// Printed offsets are not all multiples of four, so they are indexes.
`define SLO_IDX_LANE1_DEEMPH 8'h12
`define SLO_IDX_LANE0_DEEMPH 8'h13
`define SLO_IDX_LANE2_DEEMPH 8'h14
`define SLO_IDX_LANE3_DEEMPH 8'h15
`define SLO_IDX_PLL_FACTOR 8'h16
`define SLO_IDX_OVR_ROUTE 8'h1a
`define SLO_IDX_SWING_OVR 8'h1b
`define SLO_IDX_IRQ_STATUS 8'h20
`define SLO_IDX_IRQ_MASK 8'h21
// Field positions.
`define SLO_DEEMPH_MSB 7
`define SLO_DEEMPH_LSB 2
`define SLO_PLL_MSB 1
`define SLO_PLL_LSB 0
`define SLO_ROUTE_BIT 1
`define SLO_SWING_MSB 7
`define SLO_SWING_LSB 5
`define SLO_OVR_EN_BIT 3
// Writable masks; other bits hold no function and read as zero.
`define SLO_MASK_DEEMPH 8'hfc
`define SLO_MASK_PLL 8'h03
`define SLO_MASK_ROUTE 8'h02
`define SLO_MASK_SWING 8'he8
`define SLO_MASK_IRQ 8'h07
// Reset values.
`define SLO_RST_REG 8'h00
// Serializer factor codes.
`define SLO_PLL_20X 2'b00
`define SLO_PLL_40X 2'b10
// Interrupt status bit positions.
`define SLO_IRQ_BAD_DEEMPH 0
`define SLO_IRQ_BAD_PLL 1
`define SLO_IRQ_OVR_RISE 2
// AXI response codes.
`define SLO_RESP_OKAY 2'b00
`define SLO_RESP_SLVERR 2'b10
`endif

// [hdl/slo_output_page.v]
// Serial link output configuration page with an AXI4-Lite register slave.
`timescale 1ns/1ns
`include "slo_map.vh"
// Overview of operation
// - De-emphasis fields store any code; non-thermometer codes raise an interrupt.
// - Separate de-emphasis field per lane, fixed offsets.
// - PLL code 00 is 20X, 10 is 40X.
// - Route bit puts overrange flag on powerdown pin.
// - Override also needs the enable bit set.
// - Three-bit swing code common to all lanes.
module slo_output_page (
   input wire clk_i,
   input wire rst_n_i,
   input wire [7:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [7:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   input wire fast_overrange_flag_i,
   input wire powerdown_pin_in_i,
   output reg powerdown_pin_o,
   output reg powerdown_pin_oe_n_o,
   output reg [23:0] lane_deemphasis_select_o,
   output reg [1:0] serializer_pll_factor_o,
   output reg serializer_20x_four_lane_o,
   output reg [2:0] output_swing_select_o,
   output reg irq_o
);

   // Register words, in stored form.
   reg [7:0] lane1_deemphasis;
   reg [7:0] lane0_deemphasis;
   reg [7:0] lane2_deemphasis;
   reg [7:0] lane3_deemphasis;
   reg [7:0] serializer_pll_factor_ctrl;
   reg [7:0] overrange_pin_route;
   reg [7:0] swing_and_override_enable;
   reg [7:0] irq_status;
   reg [7:0] irq_mask;
   // Captured write address and data.
   reg [7:0] wr_addr;
   reg wr_addr_full;
   reg [31:0] wr_data;
   reg [3:0] wr_strb;
   reg wr_data_full;
   // Pin synchronisers, two stages each.
   reg ovr_meta;
   reg ovr_sync;
   reg pdn_meta;
   reg pdn_sync;
   reg ovr_prev;
   // Combinational helpers.
   wire wr_fire;
   wire rd_fire;
   wire [7:0] wr_idx;
   wire [7:0] rd_idx;
   wire [7:0] wbyte;
   wire route_on;
   reg [7:0] next_rdata;
   reg next_rd_ok;
   reg next_wr_ok;
   reg [7:0] next_irq_set;

   // True when a code is one of the seven thermometer codes.
   function is_thermo;
      input [5:0] code;
      begin
         is_thermo = ((code & (code + 6'h01)) == 6'h00);
      end
   endfunction

   // Converts a byte address to a word index.
   function [7:0] to_idx;
      input [7:0] addr;
      begin
         to_idx = {2'b00, addr[7:2]};
      end
   endfunction

   // A write fires once both address and data are held and no answer waits.
   assign wr_fire = wr_addr_full & wr_data_full & ~s_axi_bvalid;
   assign rd_fire = s_axi_arvalid & s_axi_arready;
   assign wr_idx = to_idx(wr_addr);
   assign rd_idx = to_idx(s_axi_araddr);
   // Only the low byte lane carries register data.
   assign wbyte = wr_strb[0] ? wr_data[7:0] : 8'h00;
   // The pin is taken over only with both bits set.
   assign route_on = overrange_pin_route[`SLO_ROUTE_BIT] &
      swing_and_override_enable[`SLO_OVR_EN_BIT];

   // Decodes whether the pending write hits a mapped register.
   always @* begin
      case (wr_idx)
         `SLO_IDX_LANE1_DEEMPH, `SLO_IDX_LANE0_DEEMPH,
         `SLO_IDX_LANE2_DEEMPH, `SLO_IDX_LANE3_DEEMPH,
         `SLO_IDX_PLL_FACTOR, `SLO_IDX_OVR_ROUTE,
         `SLO_IDX_SWING_OVR, `SLO_IDX_IRQ_STATUS,
         `SLO_IDX_IRQ_MASK: begin
            next_wr_ok = 1'b1;
         end
         default: begin
            next_wr_ok = 1'b0;
         end
      endcase
   end

   // Builds the read word; unused bits read as zero.
   always @* begin
      next_rd_ok = 1'b1;
      case (rd_idx)
         `SLO_IDX_LANE1_DEEMPH: begin
            next_rdata = lane1_deemphasis;
         end
         `SLO_IDX_LANE0_DEEMPH: begin
            next_rdata = lane0_deemphasis;
         end
         `SLO_IDX_LANE2_DEEMPH: begin
            next_rdata = lane2_deemphasis;
         end
         `SLO_IDX_LANE3_DEEMPH: begin
            next_rdata = lane3_deemphasis;
         end
         `SLO_IDX_PLL_FACTOR: begin
            next_rdata = serializer_pll_factor_ctrl;
         end
         `SLO_IDX_OVR_ROUTE: begin
            next_rdata = overrange_pin_route;
         end
         `SLO_IDX_SWING_OVR: begin
            next_rdata = swing_and_override_enable;
         end
         `SLO_IDX_IRQ_STATUS: begin
            next_rdata = irq_status;
         end
         `SLO_IDX_IRQ_MASK: begin
            next_rdata = irq_mask;
         end
         default: begin
            next_rdata = 8'h00;
            next_rd_ok = 1'b0;
         end
      endcase
   end

   // Collects this cycle's interrupt events.
   always @* begin
      next_irq_set = 8'h00;
      if (wr_fire & wbyte != 8'h00 & wr_idx >= `SLO_IDX_LANE1_DEEMPH &
         wr_idx <= `SLO_IDX_LANE3_DEEMPH) begin
         // A non-thermometer de-emphasis code was written.
         next_irq_set[`SLO_IRQ_BAD_DEEMPH] =
            ~is_thermo(wbyte[`SLO_DEEMPH_MSB:`SLO_DEEMPH_LSB]);
      end
      if (wr_fire & wr_idx == `SLO_IDX_PLL_FACTOR) begin
         // Codes 01 and 11 are unused and flagged.
         next_irq_set[`SLO_IRQ_BAD_PLL] = wbyte[`SLO_PLL_LSB];
      end
      // Rising overrange flag while it drives the pin.
      next_irq_set[`SLO_IRQ_OVR_RISE] = route_on & ovr_sync & ~ovr_prev;
   end

   // Synchronises the pin inputs.
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ovr_meta <= 1'b0;
         ovr_sync <= 1'b0;
         pdn_meta <= 1'b0;
         pdn_sync <= 1'b0;
         ovr_prev <= 1'b0;
      end else begin
         ovr_meta <= fast_overrange_flag_i;
         ovr_sync <= ovr_meta;
         pdn_meta <= powerdown_pin_in_i;
         pdn_sync <= pdn_meta;
         ovr_prev <= ovr_sync;
      end
   end

   // Write channel: takes address and data in either order, then answers.
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `SLO_RESP_OKAY;
         wr_addr <= 8'h00;
         wr_addr_full <= 1'b0;
         wr_data <= 32'h0000_0000;
         wr_strb <= 4'h0;
         wr_data_full <= 1'b0;
      end else begin
         // Ready is offered only while the holding slot is empty.
         s_axi_awready <= ~wr_addr_full & ~(s_axi_awvalid & s_axi_awready);
         s_axi_wready <= ~wr_data_full & ~(s_axi_wvalid & s_axi_wready);
         if (s_axi_awvalid & s_axi_awready) begin
            wr_addr <= s_axi_awaddr;
            wr_addr_full <= 1'b1;
         end
         if (s_axi_wvalid & s_axi_wready) begin
            wr_data <= s_axi_wdata;
            wr_strb <= s_axi_wstrb;
            wr_data_full <= 1'b1;
         end
         if (wr_fire) begin
            // Unmapped addresses answer with a slave error.
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= next_wr_ok ? `SLO_RESP_OKAY : `SLO_RESP_SLVERR;
            wr_addr_full <= 1'b0;
            wr_data_full <= 1'b0;
         end else if (s_axi_bvalid & s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Read channel: one read at a time, answered the cycle after it is taken.
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= `SLO_RESP_OKAY;
      end else begin
         s_axi_arready <= ~s_axi_rvalid & ~rd_fire;
         if (rd_fire) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {24'h00_0000, next_rdata};
            s_axi_rresp <= next_rd_ok ? `SLO_RESP_OKAY : `SLO_RESP_SLVERR;
         end else if (s_axi_rvalid & s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // Configuration registers; unused positions are not stored.
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         lane1_deemphasis <= `SLO_RST_REG;
         lane0_deemphasis <= `SLO_RST_REG;
         lane2_deemphasis <= `SLO_RST_REG;
         lane3_deemphasis <= `SLO_RST_REG;
         serializer_pll_factor_ctrl <= `SLO_RST_REG;
         overrange_pin_route <= `SLO_RST_REG;
         swing_and_override_enable <= `SLO_RST_REG;
         irq_mask <= `SLO_RST_REG;
      end else if (wr_fire) begin
         case (wr_idx)
            `SLO_IDX_LANE1_DEEMPH: begin
               lane1_deemphasis <= wbyte & `SLO_MASK_DEEMPH;
            end
            `SLO_IDX_LANE0_DEEMPH: begin
               lane0_deemphasis <= wbyte & `SLO_MASK_DEEMPH;
            end
            `SLO_IDX_LANE2_DEEMPH: begin
               lane2_deemphasis <= wbyte & `SLO_MASK_DEEMPH;
            end
            `SLO_IDX_LANE3_DEEMPH: begin
               lane3_deemphasis <= wbyte & `SLO_MASK_DEEMPH;
            end
            `SLO_IDX_PLL_FACTOR: begin
               serializer_pll_factor_ctrl <= wbyte & `SLO_MASK_PLL;
            end
            `SLO_IDX_OVR_ROUTE: begin
               overrange_pin_route <= wbyte & `SLO_MASK_ROUTE;
            end
            `SLO_IDX_SWING_OVR: begin
               swing_and_override_enable <= wbyte & `SLO_MASK_SWING;
            end
            `SLO_IDX_IRQ_MASK: begin
               irq_mask <= wbyte & `SLO_MASK_IRQ;
            end
            default: begin
               // Status and unmapped writes store nothing.
            end
         endcase
      end
   end

   // Sticky status: a read clears it, but a new event in that cycle wins.
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         irq_status <= `SLO_RST_REG;
         irq_o <= 1'b0;
      end else begin
         if (rd_fire & rd_idx == `SLO_IDX_IRQ_STATUS) begin
            irq_status <= next_irq_set;
         end else begin
            irq_status <= irq_status | next_irq_set;
         end
         irq_o <= |(irq_status & irq_mask);
      end
   end

   // Drives the lane, swing, factor and pin outputs from the registers.
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         lane_deemphasis_select_o <= 24'h00_0000;
         serializer_pll_factor_o <= `SLO_PLL_20X;
         serializer_20x_four_lane_o <= 1'b1;
         output_swing_select_o <= 3'h0;
         powerdown_pin_o <= 1'b0;
         powerdown_pin_oe_n_o <= 1'b1;
      end else begin
         // Lane order on the output: 3, 2, 1, 0 from the top.
         lane_deemphasis_select_o <= {
            lane3_deemphasis[`SLO_DEEMPH_MSB:`SLO_DEEMPH_LSB],
            lane2_deemphasis[`SLO_DEEMPH_MSB:`SLO_DEEMPH_LSB],
            lane1_deemphasis[`SLO_DEEMPH_MSB:`SLO_DEEMPH_LSB],
            lane0_deemphasis[`SLO_DEEMPH_MSB:`SLO_DEEMPH_LSB]};
         serializer_pll_factor_o <=
            serializer_pll_factor_ctrl[`SLO_PLL_MSB:`SLO_PLL_LSB];
         // Software keeps this in step with the link lane mode.
         serializer_20x_four_lane_o <=
            (serializer_pll_factor_ctrl[`SLO_PLL_MSB:`SLO_PLL_LSB] ==
            `SLO_PLL_20X);
         output_swing_select_o <=
            swing_and_override_enable[`SLO_SWING_MSB:`SLO_SWING_LSB];
         // When routed, the pin is driven with the flag; else it is an input.
         powerdown_pin_o <= route_on & ovr_sync;
         powerdown_pin_oe_n_o <= ~route_on;
      end
   end

   // The synchronised pin level is kept for future powerdown control.
   wire pdn_level_unused = pdn_sync;

endmodule // slo_output_page

// [tb/slo_props.sv]
// Checker of the output page port behaviour.
`timescale 1ns/1ns
module slo_props (
   input wire clk_i,
   input wire rst_n_i,
   input wire [1:0] s_axi_bresp,
   input wire s_axi_bvalid,
   input wire s_axi_bready,
   input wire s_axi_arvalid,
   input wire s_axi_arready,
   input wire [31:0] s_axi_rdata,
   input wire s_axi_rvalid,
   input wire s_axi_rready,
   input wire fast_overrange_flag_i,
   input wire powerdown_pin_o,
   input wire powerdown_pin_oe_n_o,
   input wire [23:0] lane_deemphasis_select_o,
   input wire [1:0] serializer_pll_factor_o,
   input wire serializer_20x_four_lane_o,
   input wire [2:0] output_swing_select_o
);
   // All checks share the one clock and its reset.
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   pll_decode_a: assert property (
      serializer_20x_four_lane_o == (serializer_pll_factor_o == 2'b00))
      else $error("lane mode flag disagrees with factor code");
   pin_gate_a: assert property (
      powerdown_pin_oe_n_o |-> !powerdown_pin_o)
      else $error("pin value driven while released");
   pin_follow_a: assert property (
      !powerdown_pin_oe_n_o && !$past(powerdown_pin_oe_n_o)
      |-> powerdown_pin_o == $past(fast_overrange_flag_i, 3))
      else $error("pin does not follow overrange flag");
   bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready
      |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped early");
   rvalid_hold_a: assert property (s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped early");
   read_answer_a: assert property (s_axi_arvalid && s_axi_arready
      |=> s_axi_rvalid)
      else $error("read answer late");
   rdata_unused_a: assert property (
      s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
      else $error("unused read bits not zero");
   cfg_write_a: assert property (
      !$stable({lane_deemphasis_select_o, serializer_pll_factor_o,
      output_swing_select_o, powerdown_pin_oe_n_o}) |-> $past(s_axi_bvalid))
      else $error("settings changed without a write");
endmodule // slo_props

// [tb/slo_output_page_tb.sv]
// Self-checking bench of the output page.
`timescale 1ns/1ns
`include "slo_map.vh"
module slo_output_page_tb;
   logic clk_i = 0, rst_n_i = 0, s_axi_awvalid = 0, s_axi_wvalid = 0;
   logic s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
   logic fast_overrange_flag_i = 0, powerdown_pin_in_i = 0;
   logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
   logic [31:0] s_axi_wdata = 0;
   logic [3:0] s_axi_wstrb = 0;
   wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   wire s_axi_rvalid, powerdown_pin_o, powerdown_pin_oe_n_o, irq_o;
   wire serializer_20x_four_lane_o;
   wire [1:0] s_axi_bresp, s_axi_rresp, serializer_pll_factor_o;
   wire [31:0] s_axi_rdata;
   wire [23:0] lane_deemphasis_select_o;
   wire [2:0] output_swing_select_o;
   integer error_cnt = 0, checks = 0, cyc = 0, i;
   // Rows hold index, written byte and expected read-back.
   // Software writes zero to every unused bit position.
   logic [23:0] rows [7] = '{24'h12fcfc, 24'h130404, 24'h140c0c,
      24'h157c7c, 24'h160202, 24'h1be8e8, 24'h1a0202};
   slo_output_page u_dut (.*);
   always #25 clk_i = ~clk_i;
   // Cuts a hang short.
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         error_cnt = error_cnt + 1;
         finish_test;
      end
   end
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      checks = checks + 1;
      if (seen !== exp) begin
         error_cnt = error_cnt + 1;
         $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask
   task finish_test;
      $display("checks %0d error_cnt %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // Write cycle; address and data are released as each is taken.
   task axi_wr(input [7:0] idx, input [7:0] d, input [1:0] resp);
      logic aw, w;
      @(posedge clk_i);
      aw = 0;
      w = 0;
      s_axi_awaddr <= {idx[5:0], 2'b00};
      s_axi_wdata <= {24'h0, d};
      s_axi_wstrb <= 4'hf;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!(aw && w)) begin
         @(posedge clk_i);
         if (!aw && s_axi_awready) begin
            aw = 1;
            s_axi_awvalid <= 1'b0;
         end
         if (!w && s_axi_wready) begin
            w = 1;
            s_axi_wvalid <= 1'b0;
         end
      end
      do @(posedge clk_i); while (!s_axi_bvalid);
      chk({30'h0, s_axi_bresp}, {30'h0, resp});
      s_axi_bready <= 1'b0;
   endtask
   // Read cycle; data and response are taken at the answer edge.
   task axi_rd(input [7:0] idx, input [7:0] d, input [1:0] resp);
      @(posedge clk_i);
      s_axi_araddr <= {idx[5:0], 2'b00};
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge clk_i); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      do @(posedge clk_i); while (!s_axi_rvalid);
      chk(s_axi_rdata, {24'h0, d});
      chk({30'h0, s_axi_rresp}, {30'h0, resp});
      s_axi_rready <= 1'b0;
   endtask
   // Outputs and the seven row registers at their reset state.
   task chk_rst;
      chk({powerdown_pin_oe_n_o, serializer_20x_four_lane_o, irq_o,
         serializer_pll_factor_o, output_swing_select_o,
         lane_deemphasis_select_o}, {3'b110, 29'h0});
      foreach (rows[i]) axi_rd(rows[i][23:16], 8'h00, `SLO_RESP_OKAY);
   endtask
   initial begin
      repeat (6) @(posedge clk_i);
      rst_n_i <= 1'b1;
      @(posedge clk_i);
      chk_rst;
      foreach (rows[i]) begin
         axi_wr(rows[i][23:16], rows[i][15:8], `SLO_RESP_OKAY);
         axi_rd(rows[i][23:16], rows[i][7:0], `SLO_RESP_OKAY);
      end
      chk(lane_deemphasis_select_o, {6'h1f, 6'h03, 6'h3f, 6'h01});
      chk({serializer_pll_factor_o, serializer_20x_four_lane_o}, 3'b100);
      chk(powerdown_pin_oe_n_o, 1'b0);
      // Overrange flag reaches the pin after the synchroniser.
      fast_overrange_flag_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      chk(powerdown_pin_o, 1'b1);
      fast_overrange_flag_i <= 1'b0;
      repeat (4) @(posedge clk_i);
      chk(powerdown_pin_o, 1'b0);
      // Enable off releases the pin even with the route bit set.
      axi_wr(8'h1b, 8'h00, `SLO_RESP_OKAY);
      @(posedge clk_i);
      chk(powerdown_pin_oe_n_o, 1'b1);
      for (i = 0; i < 8; i = i + 1) begin
         axi_wr(8'h1b, {i[2:0], 5'h08}, `SLO_RESP_OKAY);
         @(posedge clk_i);
         chk(output_swing_select_o, i[2:0]);
      end
      // Bad thermometer and unused factor code raise masked events.
      axi_wr(8'h14, 8'h08, `SLO_RESP_OKAY);
      axi_wr(8'h16, 8'h01, `SLO_RESP_OKAY);
      chk(irq_o, 1'b0);
      axi_wr(8'h21, 8'h07, `SLO_RESP_OKAY);
      repeat (2) @(posedge clk_i);
      chk(irq_o, 1'b1);
      axi_rd(8'h20, 8'h07, `SLO_RESP_OKAY);
      repeat (3) @(posedge clk_i);
      chk(irq_o, 1'b0);
      axi_rd(8'h20, 8'h00, `SLO_RESP_OKAY);
      // Factor 20X agrees with the default link lane mode of 01h.
      axi_wr(8'h16, 8'h00, `SLO_RESP_OKAY);
      @(posedge clk_i);
      chk({serializer_pll_factor_o, serializer_20x_four_lane_o}, 3'b001);
      // Unmapped place answers with an error.
      axi_wr(8'h30, 8'h55, `SLO_RESP_SLVERR);
      axi_rd(8'h30, 8'h00, `SLO_RESP_SLVERR);
      // Reset in mid-run restores the checked output defaults and the seven row registers.
      rst_n_i <= 1'b0;
      repeat (6) @(posedge clk_i);
      rst_n_i <= 1'b1;
      @(posedge clk_i);
      chk_rst;
      finish_test;
   end
endmodule // slo_output_page_tb
bind slo_output_page slo_props u_props (.*);
